//--- shared/msa_pkg.sv
package msa_pkg;

    // Memory geometry
    localparam int MSA_BLOCK_BYTES   = 4096;
    localparam int MSA_OFS_W         = 12;
    localparam int MSA_WORD_IDX_W    = 10;
    localparam int MSA_DATA_W        = 32;
    localparam int MSA_LANES         = 4;

    // Device variants and their block counts
    localparam int MSA_VAR_8BIT      = 0;
    localparam int MSA_VAR_32BIT     = 1;
    localparam int MSA_BLOCKS_8BIT   = 3;
    localparam int MSA_BLOCKS_32BIT  = 16;

    // Named blocks of the 8-bit variant
    localparam int MSA_LOWEST_BLOCK  = 0;
    localparam int MSA_MIDDLE_BLOCK  = 1;

    // Address map
    localparam logic [31:0] MSA_BANK_BOUNDARY = 32'h20000000;
    localparam logic [31:0] MSA_BASE_32BIT    = 32'h1FFF8000;
    localparam logic [31:0] MSA_BASE_8BIT     = 32'h00000000;

    typedef enum logic [1:0] {
        MSA_SIZE_BYTE = 2'b00,
        MSA_SIZE_HALF = 2'b01,
        MSA_SIZE_WORD = 2'b10
    } msa_size_e;

    // Byte lanes touched by an access of a given size at a given offset
    function automatic logic [3:0] msa_byte_enables(input logic [1:0] size, input logic [1:0] ofs);
        logic [3:0] be;
        be = 4'h0;
        unique case (size)
            MSA_SIZE_BYTE: be = 4'(4'h1 << ofs);
            MSA_SIZE_HALF: be = ofs[1] ? 4'hC : 4'h3;
            default:       be = 4'hF;
        endcase
        return be;
    endfunction : msa_byte_enables

endpackage : msa_pkg

//--- rtl/msa_block_arb.sv
module msa_block_arb
    import msa_pkg::*;
(
    input  wire logic cpu_req,
    input  wire logic cpu_pend,
    input  wire logic dma_req,
    input  wire logic dma_pend,
    input  wire logic dbg_req,
    input  wire logic cpu_first,
    output logic      gnt_cpu,
    output logic      gnt_dma,
    output logic      gnt_dbg
);

    logic cpu_wins;

    // A master left waiting goes ahead of a fresh request, else fixed priority
    always_comb
    begin
        cpu_wins = 1'b0;
        if (cpu_req && dma_req)
        begin
            if (cpu_pend != dma_pend)
                cpu_wins = cpu_pend;
            else
                cpu_wins = cpu_first;
        end
        else
            cpu_wins = cpu_req;
    end

    // Decided anew every cycle from the requests present now
    always_comb
    begin
        gnt_dbg = dbg_req;
        gnt_cpu = !dbg_req && cpu_req && cpu_wins;
        gnt_dma = !dbg_req && dma_req && !cpu_wins;
    end

endmodule : msa_block_arb

//--- rtl/msa_block_ram.sv
module msa_block_ram
    import msa_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      en,
    input  wire logic                      we,
    input  wire logic [MSA_LANES-1:0]      be,
    input  wire logic [MSA_WORD_IDX_W-1:0] word_addr,
    input  wire logic [MSA_DATA_W-1:0]     wdata,
    output logic      [MSA_DATA_W-1:0]     rdata
);

    // No reset and no power gating: contents stay put and start unknown
    logic [MSA_DATA_W-1:0] mem [2**MSA_WORD_IDX_W];

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < MSA_LANES; i++)
        begin
            if (en && we && be[i])
                mem[word_addr][8*i +: 8] <= wdata[8*i +: 8];
        end
    end

    assign rdata = mem[word_addr];

endmodule : msa_block_ram

//--- rtl/msa_multi_bank_sram_arbiter.sv
module msa_multi_bank_sram_arbiter
    import msa_pkg::*;
#(
    parameter  int VARIANT    = MSA_VAR_8BIT,
    parameter  int NUM_BLOCKS = MSA_BLOCKS_8BIT,
    localparam int CPU_DW     = (VARIANT == MSA_VAR_32BIT) ? 32 : 8,
    localparam int BLK_W      = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1
)(
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  cpu_req,
    input  wire logic                  cpu_we,
    input  wire logic                  cpu_fetch,
    input  wire logic [1:0]            cpu_size,
    input  wire logic [31:0]           cpu_addr,
    input  wire logic [CPU_DW-1:0]     cpu_wdata,
    output logic                       cpu_busy,
    output logic                       cpu_ack,
    output logic                       cpu_err,
    output logic      [CPU_DW-1:0]     cpu_rdata,
    input  wire logic                  dma_req,
    input  wire logic                  dma_we,
    input  wire logic [1:0]            dma_size,
    input  wire logic [31:0]           dma_addr,
    input  wire logic [31:0]           dma_wdata,
    output logic                       dma_busy,
    output logic                       dma_ack,
    output logic                       dma_err,
    output logic      [31:0]           dma_rdata,
    input  wire logic                  trace_active,
    input  wire logic                  dbg_req,
    input  wire logic                  dbg_we,
    input  wire logic [MSA_OFS_W-1:0]  dbg_addr,
    input  wire logic [31:0]           dbg_wdata,
    output logic                       dbg_ack,
    output logic                       dbg_err,
    output logic      [31:0]           dbg_rdata
);

    localparam bit              IS32    = (VARIANT == MSA_VAR_32BIT);
    localparam logic [31:0]     BASE    = IS32 ? MSA_BASE_32BIT : MSA_BASE_8BIT;
    localparam logic [31:0]     SPAN    = 32'(NUM_BLOCKS * MSA_BLOCK_BYTES);
    localparam logic [BLK_W-1:0] TOP_IDX = BLK_W'(NUM_BLOCKS - 1);
    if (VARIANT != MSA_VAR_8BIT && VARIANT != MSA_VAR_32BIT)
        $error("VARIANT must be the 8-bit or the 32-bit variant");
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > (IS32 ? MSA_BLOCKS_32BIT : MSA_BLOCKS_8BIT))
        $error("NUM_BLOCKS out of range for this variant");
    logic                   trace_lock;
    logic                   cpu_act;
    logic                   cpu_a_we;
    logic                   cpu_a_fetch;
    logic [1:0]             cpu_a_size;
    logic [31:0]            cpu_a_addr;
    logic [CPU_DW-1:0]      cpu_a_wdata;
    logic [31:0]            cpu_off;
    logic [BLK_W-1:0]       cpu_blk;
    logic                   cpu_in_range;
    logic                   cpu_fetch_bad;
    logic                   cpu_bad;
    logic [3:0]             cpu_be;
    logic [31:0]            cpu_wword;
    logic [4:0]             cpu_shift;
    logic                   cpu_won;
    logic                   cpu_h_we;
    logic                   cpu_h_fetch;
    logic [1:0]             cpu_h_size;
    logic [31:0]            cpu_h_addr;
    logic [CPU_DW-1:0]      cpu_h_wdata;
    logic                   dma_act;
    logic                   dma_a_we;
    logic [1:0]             dma_a_size;
    logic [31:0]            dma_a_addr;
    logic [31:0]            dma_a_wdata;
    logic [31:0]            dma_off;
    logic [BLK_W-1:0]       dma_blk;
    logic                   dma_in_range;
    logic                   dma_bad;
    logic [3:0]             dma_be;
    logic                   dma_won;
    logic                   dma_h_we;
    logic [1:0]             dma_h_size;
    logic [31:0]            dma_h_addr;
    logic [31:0]            dma_h_wdata;
    logic                   dbg_won;
    logic [NUM_BLOCKS-1:0]  cpu_bgnt;
    logic [NUM_BLOCKS-1:0]  dma_bgnt;
    logic [NUM_BLOCKS-1:0]  dbg_bgnt;
    logic [31:0]            blk_rdata [NUM_BLOCKS];

    // The 32-bit variant has no trace store
    assign trace_lock = !IS32 && trace_active;
    // A waiting request replays from its holding registers
    assign cpu_act     = cpu_req || cpu_busy;
    assign cpu_a_we    = cpu_busy ? cpu_h_we    : cpu_we;
    assign cpu_a_fetch = cpu_busy ? cpu_h_fetch : cpu_fetch;
    assign cpu_a_size  = cpu_busy ? cpu_h_size  : cpu_size;
    assign cpu_a_addr  = cpu_busy ? cpu_h_addr  : cpu_addr;
    assign cpu_a_wdata = cpu_busy ? cpu_h_wdata : cpu_wdata;
    assign dma_act     = dma_req || dma_busy;
    assign dma_a_we    = dma_busy ? dma_h_we    : dma_we;
    assign dma_a_size  = dma_busy ? dma_h_size  : dma_size;
    assign dma_a_addr  = dma_busy ? dma_h_addr  : dma_addr;
    assign dma_a_wdata = dma_busy ? dma_h_wdata : dma_wdata;

    // Block select from the bits above the block offset
    assign cpu_off       = cpu_a_addr - BASE;
    assign cpu_in_range  = cpu_off < SPAN;
    assign cpu_blk       = cpu_off[MSA_OFS_W +: BLK_W];
    assign cpu_fetch_bad = cpu_a_fetch && (!IS32 || cpu_a_addr >= MSA_BANK_BOUNDARY);
    assign cpu_bad       = !cpu_in_range || cpu_fetch_bad
                           || (trace_lock && cpu_blk == TOP_IDX);
    assign cpu_be        = msa_byte_enables(IS32 ? cpu_a_size : MSA_SIZE_BYTE, cpu_off[1:0]);
    assign cpu_wword     = IS32 ? 32'(cpu_a_wdata) : {4{cpu_a_wdata[7:0]}};
    assign cpu_shift     = IS32 ? 5'h00 : {cpu_off[1:0], 3'b000};

    assign dma_off       = dma_a_addr - BASE;
    assign dma_in_range  = dma_off < SPAN;
    assign dma_blk       = dma_off[MSA_OFS_W +: BLK_W];
    assign dma_bad       = !dma_in_range || (trace_lock && dma_blk == TOP_IDX);
    assign dma_be        = msa_byte_enables(dma_a_size, dma_off[1:0]);

    assign cpu_won = |cpu_bgnt;
    assign dma_won = |dma_bgnt;
    assign dbg_won = |dbg_bgnt;

    // One arbiter and one storage block per 4 KB block
    for (genvar b = 0; b < NUM_BLOCKS; b++)
    begin : g_block
        logic                      breq_cpu;
        logic                      breq_dma;
        logic                      breq_dbg;
        logic                      ram_en;
        logic                      ram_we;
        logic [3:0]                ram_be;
        logic [MSA_WORD_IDX_W-1:0] ram_idx;
        logic [31:0]               ram_wd;

        // Each master steers only the block it addresses
        assign breq_cpu = cpu_act && !cpu_bad && cpu_blk == BLK_W'(b);
        assign breq_dma = dma_act && !dma_bad && dma_blk == BLK_W'(b);
        assign breq_dbg = (b == NUM_BLOCKS - 1) && dbg_req && trace_lock;

        msa_block_arb u_arb (
            .cpu_req   (breq_cpu),
            .cpu_pend  (cpu_busy),
            .dma_req   (breq_dma),
            .dma_pend  (dma_busy),
            .dbg_req   (breq_dbg),
            .cpu_first (IS32 || b != MSA_MIDDLE_BLOCK),
            .gnt_cpu   (cpu_bgnt[b]),
            .gnt_dma   (dma_bgnt[b]),
            .gnt_dbg   (dbg_bgnt[b])
        );

        // Winner drives the block in the very cycle of its request
        always_comb
        begin
            ram_en  = 1'b0;
            ram_we  = 1'b0;
            ram_be  = 4'h0;
            ram_idx = '0;
            ram_wd  = '0;
            if (dbg_bgnt[b])
            begin
                ram_en  = 1'b1;
                ram_we  = dbg_we;
                ram_be  = 4'hF;
                ram_idx = dbg_addr[MSA_OFS_W-1:2];
                ram_wd  = dbg_wdata;
            end
            else if (cpu_bgnt[b])
            begin
                ram_en  = 1'b1;
                ram_we  = cpu_a_we;
                ram_be  = cpu_be;
                ram_idx = cpu_off[MSA_OFS_W-1:2];
                ram_wd  = cpu_wword;
            end
            else if (dma_bgnt[b])
            begin
                ram_en  = 1'b1;
                ram_we  = dma_a_we;
                ram_be  = dma_be;
                ram_idx = dma_off[MSA_OFS_W-1:2];
                ram_wd  = dma_a_wdata;
            end
        end

        msa_block_ram u_ram (
            .clock     (clock),
            .en        (ram_en),
            .we        (ram_we),
            .be        (ram_be),
            .word_addr (ram_idx),
            .wdata     (ram_wd),
            .rdata     (blk_rdata[b])
        );
    end

    // Hold a new request while it waits for its block
    always_ff @(posedge clock)
    begin
        if (cpu_req && !cpu_busy)
        begin
            cpu_h_we    <= cpu_we;
            cpu_h_fetch <= cpu_fetch;
            cpu_h_size  <= cpu_size;
            cpu_h_addr  <= cpu_addr;
            cpu_h_wdata <= cpu_wdata;
        end
        if (dma_req && !dma_busy)
        begin
            dma_h_we    <= dma_we;
            dma_h_size  <= dma_size;
            dma_h_addr  <= dma_addr;
            dma_h_wdata <= dma_wdata;
        end
    end

    // Losers stall; answer one cycle after the access cycle
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cpu_busy <= 1'b0;
            cpu_ack  <= 1'b0;
            cpu_err  <= 1'b0;
        end
        else
        begin
            cpu_busy <= cpu_act && !cpu_bad && !cpu_won;
            cpu_ack  <= cpu_act && (cpu_bad || cpu_won);
            cpu_err  <= cpu_act && cpu_bad;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dma_busy <= 1'b0;
            dma_ack  <= 1'b0;
            dma_err  <= 1'b0;
            dbg_ack  <= 1'b0;
            dbg_err  <= 1'b0;
        end
        else
        begin
            dma_busy <= dma_act && !dma_bad && !dma_won;
            dma_ack  <= dma_act && (dma_bad || dma_won);
            dma_err  <= dma_act && dma_bad;
            dbg_ack  <= dbg_req;
            dbg_err  <= dbg_req && !trace_lock;
        end
    end

    // Read data registered from the block that served the access
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cpu_rdata <= '0;
            dma_rdata <= '0;
            dbg_rdata <= '0;
        end
        else
        begin
            if (cpu_won && !cpu_a_we)
                cpu_rdata <= CPU_DW'(blk_rdata[cpu_blk] >> cpu_shift);
            if (dma_won && !dma_a_we)
                dma_rdata <= blk_rdata[dma_blk];
            if (dbg_won && !dbg_we)
                dbg_rdata <= blk_rdata[NUM_BLOCKS-1];
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_cpu_lose;
        cpu_act && !cpu_bad && !cpu_won;
    endsequence
    sequence s_dma_lose;
        dma_act && !dma_bad && !dma_won;
    endsequence
    sequence s_contend;
        cpu_act && dma_act && !cpu_bad && !dma_bad && cpu_blk == dma_blk && !cpu_busy && !dma_busy;
    endsequence
    a_trace_refuse_cpu: assert property (trace_lock && cpu_act && cpu_in_range && cpu_blk == TOP_IDX
        |=> cpu_ack && cpu_err && !cpu_busy)
        else $error("CPU reached the trace block while tracing");
    a_trace_dbg_owns: assert property (dbg_req && trace_lock |-> dbg_won ##1 dbg_ack && !dbg_err)
        else $error("Debugger not served while tracing");
    a_zero_wait_cpu: assert property (cpu_won |=> cpu_ack && !cpu_err && !cpu_busy)
        else $error("Granted CPU access did not finish in one cycle");
    a_split_blocks: assert property (cpu_act && dma_act && !cpu_bad && !dma_bad
        && cpu_blk != dma_blk |-> cpu_won && dma_won ##1 cpu_ack && dma_ack)
        else $error("Accesses to different blocks stalled");
    a_middle_dma_wins: assert property (s_contend and (!IS32 && cpu_blk == BLK_W'(MSA_MIDDLE_BLOCK))
        |-> dma_won && !cpu_won)
        else $error("Middle block not given to the DMA hub");
    a_outer_cpu_wins: assert property (s_contend and (!IS32 && cpu_blk != BLK_W'(MSA_MIDDLE_BLOCK)
        && !dbg_won) |-> cpu_won && !dma_won)
        else $error("Outer block not given to the CPU");
    a_cpu32_first: assert property (s_contend and IS32 |-> cpu_won ##1 dma_busy)
        else $error("CPU did not win in the 32-bit variant");
    a_cpu_loser_next: assert property (s_cpu_lose ##1 !trace_lock |-> cpu_busy && cpu_won ##1 cpu_ack)
        else $error("Waiting CPU not served the cycle after");
    a_dma_loser_next: assert property (s_dma_lose ##1 !trace_lock |-> dma_busy && dma_won ##1 dma_ack)
        else $error("Waiting DMA hub not served the cycle after");
    a_range_refuse: assert property (cpu_act && !cpu_in_range |=> cpu_ack && cpu_err)
        else $error("Out-of-range CPU address not refused");
    a_fetch_high: assert property (cpu_act && cpu_a_fetch && cpu_a_addr >= MSA_BANK_BOUNDARY
        |-> !cpu_won ##1 cpu_err)
        else $error("Fetch above the bank boundary accepted");
    a_one_owner: assert property ($onehot0({cpu_bgnt[cpu_blk], dma_bgnt[cpu_blk], dbg_bgnt[cpu_blk]}))
        else $error("Two masters granted one block");
endmodule : msa_multi_bank_sram_arbiter

//--- tb/msa_master_model.sv
module msa_master_model
    import msa_pkg::*;
#(
    parameter int DW = 32
)(
    input  wire logic          clock,
    input  wire logic          busy,
    input  wire logic          ack,
    input  wire logic          err_in,
    input  wire logic [DW-1:0] rdata_in,
    output logic               req,
    output logic               we,
    output logic               fetch,
    output logic [1:0]         size,
    output logic [31:0]        addr,
    output logic [DW-1:0]      wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        req   = 1'h0;
        we    = 1'h0;
        fetch = 1'h0;
        size  = 2'h0;
        addr  = 32'h0;
        wdata = '0;
    end

    // One-cycle request, then wait for the answer; called just after a rising edge
    task automatic access(input logic w, input logic f, input logic [1:0] sz, input logic [31:0] a,
                          input logic [DW-1:0] d, output logic [DW-1:0] rd, output logic e, output int lat);
        lat = 0;
        while (busy === 1'h1 && lat < 20)
        begin
            @(posedge clock);
            #1;
            lat++;
        end
        req   = 1'h1;
        we    = w;
        fetch = f;
        size  = sz;
        addr  = a;
        wdata = d;
        @(posedge clock);
        #1;
        // Released lines show the inverse, never the stale value
        req   = 1'h0;
        we    = ~w;
        fetch = ~f;
        size  = ~sz;
        addr  = ~a;
        wdata = ~d;
        lat   = 1;
        while (ack !== 1'h1 && lat < 20)
        begin
            @(posedge clock);
            #1;
            lat++;
        end
        rd = rdata_in;
        e  = err_in;
        // One idle edge before a following call raises req again
        @(posedge clock);
        #1;
    endtask : access

endmodule : msa_master_model

//--- tb/msa_multi_bank_sram_arbiter_tb_top.sv
module msa_multi_bank_sram_arbiter_tb_top
    import msa_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic m; logic w; logic f; logic [1:0] sz; logic [31:0] a; logic [31:0] d; logic [31:0] x; logic e;
    } msa_row_s;

    logic        clock = 1'h0;
    logic        srst  = 1'h1;
    logic        cpu_req, cpu_we, cpu_fetch, cpu_busy, cpu_ack, cpu_err;
    logic [1:0]  cpu_size, dma_size;
    logic [31:0] cpu_addr, dma_addr, dma_wdata, dma_rdata, dbg_rdata, rd32, rd32b;
    logic        c3_req, c3_we, c3_fetch, c3_busy, c3_ack, c3_err, d3_req, d3_we, d3_busy, d3_ack, d3_err;
    logic [1:0]  c3_size, d3_size;
    logic [31:0] c3_addr, c3_wdata, c3_rdata, d3_addr, d3_wdata, d3_rdata;
    logic [31:0] dbg_wdata    = 32'h0;
    logic [7:0]  cpu_wdata, cpu_rdata, rd8;
    logic        dma_req, dma_we, dma_busy, dma_ack, dma_err, e, e2;
    logic        trace_active = 1'h0;
    logic        dbg_req      = 1'h0;
    logic        dbg_we       = 1'h0;
    logic        dbg_ack, dbg_err;
    logic [11:0] dbg_addr     = 12'h0;
    logic [31:0] bases [3]    = '{32'h0, 32'h1004, 32'h2008};
    int          n_fail       = 0;
    int          cmp_count    = 0;
    int          lat, lat2;
    msa_row_s    r;
    msa_row_s    rows [14] = '{
        '{1'h1, 1'h1, 1'h0, 2'h2, 32'h0000, 32'h44332211, 32'h0, 1'h0},
        '{1'h0, 1'h0, 1'h0, 2'h0, 32'h0001, 32'h0, 32'h22, 1'h0},
        '{1'h0, 1'h1, 1'h0, 2'h0, 32'h0002, 32'hAB, 32'h0, 1'h0},
        '{1'h1, 1'h0, 1'h0, 2'h2, 32'h0000, 32'h0, 32'h44AB2211, 1'h0},
        '{1'h1, 1'h1, 1'h0, 2'h2, 32'h1004, 32'h0, 32'h0, 1'h0},
        '{1'h1, 1'h1, 1'h0, 2'h1, 32'h1006, 32'hBEEF0000, 32'h0, 1'h0},
        '{1'h1, 1'h0, 1'h0, 2'h2, 32'h1004, 32'h0, 32'hBEEF0000, 1'h0},
        '{1'h1, 1'h1, 1'h0, 2'h2, 32'h2008, 32'h11111111, 32'h0, 1'h0},
        '{1'h1, 1'h1, 1'h0, 2'h0, 32'h2009, 32'h0000CD00, 32'h0, 1'h0},
        '{1'h0, 1'h0, 1'h0, 2'h0, 32'h2009, 32'h0, 32'hCD, 1'h0},
        '{1'h1, 1'h0, 1'h0, 2'h2, 32'h2008, 32'h0, 32'h1111CD11, 1'h0},
        '{1'h0, 1'h0, 1'h0, 2'h0, 32'h3000, 32'h0, 32'h0, 1'h1},
        '{1'h1, 1'h1, 1'h0, 2'h2, 32'h3000, 32'h1, 32'h0, 1'h1},
        '{1'h0, 1'h0, 1'h1, 2'h0, 32'h0000, 32'h0, 32'h0, 1'h1}};

    always #5 clock = ~clock;

    msa_multi_bank_sram_arbiter #(.VARIANT(MSA_VAR_8BIT), .NUM_BLOCKS(MSA_BLOCKS_8BIT)) u_dut (
        .clock(clock), .srst(srst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_fetch(cpu_fetch),
        .cpu_size(cpu_size), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_busy(cpu_busy),
        .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata), .dma_req(dma_req), .dma_we(dma_we),
        .dma_size(dma_size), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_busy(dma_busy),
        .dma_ack(dma_ack), .dma_err(dma_err), .dma_rdata(dma_rdata), .trace_active(trace_active),
        .dbg_req(dbg_req), .dbg_we(dbg_we), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
        .dbg_ack(dbg_ack), .dbg_err(dbg_err), .dbg_rdata(dbg_rdata));

    msa_master_model #(.DW(8)) u_cpu (
        .clock(clock), .busy(cpu_busy), .ack(cpu_ack), .err_in(cpu_err), .rdata_in(cpu_rdata),
        .req(cpu_req), .we(cpu_we), .fetch(cpu_fetch), .size(cpu_size), .addr(cpu_addr), .wdata(cpu_wdata));

    msa_master_model #(.DW(32)) u_dma (
        .clock(clock), .busy(dma_busy), .ack(dma_ack), .err_in(dma_err), .rdata_in(dma_rdata),
        .req(dma_req), .we(dma_we), .fetch(), .size(dma_size), .addr(dma_addr), .wdata(dma_wdata));

    msa_multi_bank_sram_arbiter #(.VARIANT(MSA_VAR_32BIT), .NUM_BLOCKS(MSA_BLOCKS_32BIT)) u_dut32 (
        .clock(clock), .srst(srst), .cpu_req(c3_req), .cpu_we(c3_we), .cpu_fetch(c3_fetch),
        .cpu_size(c3_size), .cpu_addr(c3_addr), .cpu_wdata(c3_wdata), .cpu_busy(c3_busy),
        .cpu_ack(c3_ack), .cpu_err(c3_err), .cpu_rdata(c3_rdata), .dma_req(d3_req), .dma_we(d3_we),
        .dma_size(d3_size), .dma_addr(d3_addr), .dma_wdata(d3_wdata), .dma_busy(d3_busy),
        .dma_ack(d3_ack), .dma_err(d3_err), .dma_rdata(d3_rdata), .trace_active(trace_active),
        .dbg_req(dbg_req), .dbg_we(dbg_we), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
        .dbg_ack(), .dbg_err(), .dbg_rdata());

    msa_master_model #(.DW(32)) u_cpu32 (
        .clock(clock), .busy(c3_busy), .ack(c3_ack), .err_in(c3_err), .rdata_in(c3_rdata),
        .req(c3_req), .we(c3_we), .fetch(c3_fetch), .size(c3_size), .addr(c3_addr), .wdata(c3_wdata));

    msa_master_model #(.DW(32)) u_dma32 (
        .clock(clock), .busy(d3_busy), .ack(d3_ack), .err_in(d3_err), .rdata_in(d3_rdata),
        .req(d3_req), .we(d3_we), .fetch(), .size(d3_size), .addr(d3_addr), .wdata(d3_wdata));

    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic dbg_access(input logic w, input logic [11:0] a, input logic [31:0] d,
                              output logic [31:0] rd, output logic er);
        dbg_req   = 1'h1;
        dbg_we    = w;
        dbg_addr  = a;
        dbg_wdata = d;
        @(posedge clock);
        #1;
        dbg_req   = 1'h0;
        dbg_we    = ~w;
        dbg_addr  = ~a;
        dbg_wdata = ~d;
        chk_bit("dbg_ack", 1'h1, dbg_ack);
        rd = dbg_rdata;
        er = dbg_err;
        @(posedge clock);
        #1;
    endtask : dbg_access

    task automatic do_reset();
        srst = 1'h1;
        repeat (10) @(posedge clock);
        #1;
        chk_word("idle", 32'h0, 32'({cpu_busy, cpu_ack, cpu_err, dma_busy, dma_ack, dma_err, dbg_ack, dbg_err}));
        srst = 1'h0;
        @(posedge clock);
        #1;
    endtask : do_reset

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (5000) @(posedge clock);
        n_fail++;
        stop_test();
    end

    initial
    begin
        #1;
        do_reset();
        foreach (rows[i])
        begin
            r = rows[i];
            if (r.m)
                u_dma.access(r.w, r.f, r.sz, r.a, r.d, rd32, e, lat);
            else
            begin
                u_cpu.access(r.w, r.f, r.sz, r.a, r.d[7:0], rd8, e, lat);
                rd32 = {24'h0, rd8};
            end
            chk_bit("err", r.e, e);
            chk_word("latency", 32'h1, 32'(lat));
            if (!r.w && !r.e)
                chk_word("rdata", r.x, rd32);
        end
        // Same-block contention on every block, then different blocks together
        for (int k = 0; k < 4; k++)
        begin
            fork
                u_cpu.access(1'h0, 1'h0, 2'h0, bases[k % 3], 8'h0, rd8, e, lat);
                u_dma.access(1'h0, 1'h0, 2'h2, (k == 3) ? 32'h1004 : bases[k], 32'h0, rd32, e2, lat2);
            join
            chk_word("cpu_latency", (k == 1) ? 32'h2 : 32'h1, 32'(lat));
            chk_word("dma_latency", (k == 0 || k == 2) ? 32'h2 : 32'h1, 32'(lat2));
        end
        // 32-bit variant: both banks, fetch limit, span limit, CPU first on contention
        u_cpu32.access(1'h1, 1'h0, 2'h2, 32'h20007FFC, 32'h12345678, rd32, e, lat);
        u_dma32.access(1'h0, 1'h0, 2'h2, 32'h20007FFC, 32'h0, rd32, e, lat);
        chk_word("rdata32", 32'h12345678, rd32);
        u_cpu32.access(1'h0, 1'h1, 2'h2, 32'h1FFFFFFC, 32'h0, rd32, e, lat);
        chk_bit("fetch_err", 1'h0, e);
        u_cpu32.access(1'h0, 1'h1, 2'h2, 32'h20000000, 32'h0, rd32, e, lat);
        chk_bit("fetch_err", 1'h1, e);
        u_dma32.access(1'h0, 1'h0, 2'h2, 32'h20008000, 32'h0, rd32, e, lat);
        chk_bit("range_err", 1'h1, e);
        fork
            u_cpu32.access(1'h0, 1'h0, 2'h2, 32'h1FFF9000, 32'h0, rd32, e, lat);
            u_dma32.access(1'h0, 1'h0, 2'h2, 32'h1FFF9004, 32'h0, rd32b, e2, lat2);
        join
        chk_word("cpu32_latency", 32'h1, 32'(lat));
        chk_word("dma32_latency", 32'h2, 32'(lat2));
        trace_active = 1'h1;
        dbg_access(1'h1, 12'h008, 32'hCAFEF00D, rd32, e);
        chk_bit("dbg_err", 1'h0, e);
        dbg_access(1'h0, 12'h008, 32'h0, rd32, e);
        chk_word("dbg_rdata", 32'hCAFEF00D, rd32);
        u_cpu.access(1'h0, 1'h0, 2'h0, 32'h2008, 8'h0, rd8, e, lat);
        chk_bit("cpu_err", 1'h1, e);
        u_dma.access(1'h1, 1'h0, 2'h2, 32'h2000, 32'h5, rd32, e, lat);
        chk_bit("dma_err", 1'h1, e);
        trace_active = 1'h0;
        dbg_access(1'h0, 12'h008, 32'h0, rd32, e);
        chk_bit("dbg_err", 1'h1, e);
        u_dma.access(1'h0, 1'h0, 2'h2, 32'h2008, 32'h0, rd32, e, lat);
        chk_word("dma_rdata", 32'hCAFEF00D, rd32);
        do_reset();
        u_cpu.access(1'h0, 1'h0, 2'h0, 32'h0001, 8'h0, rd8, e, lat);
        chk_word("kept", 32'h22, {24'h0, rd8});
        stop_test();
    end

endmodule : msa_multi_bank_sram_arbiter_tb_top
